// ==== pkg/pwm_duty_compare_pkg.sv ====
// Operation
// - duty held in high shadow register plus 2-bit latch for glitchless updates
// - output cleared when shadow plus latch equals timer count with two fine bits
// - duty longer than period keeps output high; only shutdown or disable clears it
// - period timer prescaler divides by 1, 4 or 16
// - usable resolution limited to log2 of oscillator over pwm frequency
// - first channel offers auto-shutdown; second channel has none
package pwm_duty_compare_pkg;
	// ==========================================
	// widths
	localparam int DUTY_W     = 10;
	localparam int FINE_W     = 2;
	localparam int BYTE_W     = 8;
	localparam int PRESCALE_W = 2;
	// ==========================================
	// prescaler selections
	localparam logic [1:0] PRESCALE_DIV1  = 2'h0;
	localparam logic [1:0] PRESCALE_DIV4  = 2'h1;
	localparam logic [1:0] PRESCALE_DIV16 = 2'h2;
	// ==========================================
	// reset, last-count and zero-duty values
	localparam logic [7:0] COUNT_RESET  = 8'h00;
	localparam logic [1:0] FINE_RESET   = 2'h0;
	localparam logic [3:0] PRE_RESET    = 4'h0;
	localparam logic [3:0] PRE_LAST16   = 4'hF;
	localparam logic [1:0] PRE_LAST4    = 2'h3;
	localparam logic [1:0] FINE_LAST    = 2'h3;
	localparam logic [9:0] DUTY_ZERO    = 10'h000;
endpackage

// ==== hw/pwm_duty_compare.sv ====
`timescale 1ns/1ps
module pwm_duty_compare #(
	parameter int  HAS_SHUTDOWN = 1
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// configuration from software-owned registers
	input  wire logic       pwmEnable,
	input  wire logic [7:0] periodLimitReg,
	input  wire logic [7:0] dutyWriteByte,
	input  wire logic [1:0] dutyLowBits,
	input  wire logic [1:0] prescaleSel,
	// auto-shutdown request
	input  wire logic       shutdownReq,
	// status and pin
	output logic      [7:0] periodTimerCount,
	output logic            periodMatch,
	output logic            pwmOutputPin
);
	// ==========================================
	// local state
	logic [1:0]                              qPhase_q;
	logic [3:0]                              pre_q;
	logic [7:0]                              count_q;
	logic [7:0]                              count_d;
	logic [7:0]                              dutyShadowHigh_q;
	logic [7:0]                              dutyShadowHigh_d;
	logic [1:0]                              dutyLatch_q;
	logic [1:0]                              dutyLatch_d;
	logic                                    shut_q;
	logic                                    shut_d;
	logic                                    pin_q;
	logic                                    pin_d;
	logic [1:0]                              fine;
	logic                                    qEnd;
	logic                                    step;
	logic                                    dutyHit;
	logic                                    dutyZero;
	logic [pwm_duty_compare_pkg::DUTY_W-1:0] dutyActive;
	logic [pwm_duty_compare_pkg::DUTY_W-1:0] timeNow;

	// ==========================================
	// elaboration checks
	initial begin
		if (HAS_SHUTDOWN != 0 && HAS_SHUTDOWN != 1) begin
			$error("HAS_SHUTDOWN must be 0 or 1");
		end
		if (pwm_duty_compare_pkg::BYTE_W != $bits(dutyWriteByte)) begin
			$error("duty byte width does not match the package");
		end
		if (pwm_duty_compare_pkg::FINE_W != $bits(dutyLowBits)) begin
			$error("duty fine width does not match the package");
		end
		if (pwm_duty_compare_pkg::FINE_W != $bits(qPhase_q)) begin
			$error("quarter phase width does not match the package");
		end
		if (pwm_duty_compare_pkg::PRESCALE_W != $bits(prescaleSel)) begin
			$error("prescaler select width does not match the package");
		end
		if ($bits(periodLimitReg) != $bits(periodTimerCount)) begin
			$error("period limit and timer widths differ");
		end
		if (pwm_duty_compare_pkg::BYTE_W + pwm_duty_compare_pkg::FINE_W
			!= pwm_duty_compare_pkg::DUTY_W) begin
			$error("duty width must be byte width plus fine width");
		end
	end

	// ==========================================
	// prescaler decoding, shared by step and fine-bit logic
	function automatic logic isDiv1(input logic [1:0] sel);
		isDiv1 = (sel == pwm_duty_compare_pkg::PRESCALE_DIV1);
	endfunction

	function automatic logic isDiv4(input logic [1:0] sel);
		isDiv4 = (sel == pwm_duty_compare_pkg::PRESCALE_DIV4);
	endfunction

	// select 3 is not a listed setting; it divides by 16 like select 2
	function automatic logic preWrap(input logic [1:0] sel, input logic [3:0] pre);
		logic wrap;
		if (isDiv1(sel)) begin
			wrap = 1'b1;
		end else if (isDiv4(sel)) begin
			wrap = (pre[1:0] == pwm_duty_compare_pkg::PRE_LAST4);
		end else begin
			wrap = (pre == pwm_duty_compare_pkg::PRE_LAST16);
		end
		return wrap;
	endfunction

	// ==========================================
	// quarter-cycle phase
	// four core clocks make one timer input clock
	always_ff @(posedge clk) begin
		if (rst || !pwmEnable) begin
			qPhase_q <= pwm_duty_compare_pkg::FINE_RESET;
		end else begin
			qPhase_q <= qPhase_q + 2'h1;
		end
	end
	assign qEnd = (qPhase_q == pwm_duty_compare_pkg::FINE_LAST);

	// ==========================================
	// timer prescaler, counting whole timer input clocks
	always_ff @(posedge clk) begin
		if (rst || !pwmEnable) begin
			pre_q <= pwm_duty_compare_pkg::PRE_RESET;
		end else if (step) begin
			pre_q <= pwm_duty_compare_pkg::PRE_RESET;
		end else if (qEnd) begin
			pre_q <= pre_q + 4'h1;
		end
	end
	// timer steps once per 4, 16 or 64 quarter cycles
	assign step = qEnd && preWrap(prescaleSel, pre_q);

	// ==========================================
	// fine bits
	// the two bits that advance once per duty lsb; full ten-bit resolution
	// only while the period spans the whole byte range
	always_comb begin
		if (isDiv1(prescaleSel)) begin
			fine = qPhase_q;
		end else if (isDiv4(prescaleSel)) begin
			fine = pre_q[1:0];
		end else begin
			fine = pre_q[3:2];
		end
	end

	// ==========================================
	// period timer
	assign periodMatch = pwmEnable && step && (count_q == periodLimitReg);

	// a limit written below the running count lets the timer wrap once
	always_comb begin
		count_d = count_q;
		if (periodMatch) begin
			count_d = pwm_duty_compare_pkg::COUNT_RESET;
		end else if (step) begin
			count_d = count_q + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !pwmEnable) begin
			count_q <= pwm_duty_compare_pkg::COUNT_RESET;
		end else begin
			count_q <= count_d;
		end
	end
	assign periodTimerCount = count_q;

	// ==========================================
	// double-buffered duty
	// shadow only reloads at period end, so mid-period writes cannot glitch
	always_comb begin
		dutyShadowHigh_d = dutyShadowHigh_q;
		dutyLatch_d      = dutyLatch_q;
		if (periodMatch) begin
			dutyShadowHigh_d = dutyWriteByte;
			dutyLatch_d      = dutyLowBits;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dutyShadowHigh_q <= pwm_duty_compare_pkg::COUNT_RESET;
			dutyLatch_q      <= pwm_duty_compare_pkg::FINE_RESET;
		end else begin
			dutyShadowHigh_q <= dutyShadowHigh_d;
			dutyLatch_q      <= dutyLatch_d;
		end
	end

	// ==========================================
	// shutdown, first channel only
	// a request wins over the period match that would otherwise release it
	always_comb begin
		shut_d = shut_q;
		if (shutdownReq) begin
			shut_d = 1'b1;
		end else if (periodMatch) begin
			shut_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || HAS_SHUTDOWN == 0) begin
			shut_q <= 1'b0;
		end else begin
			shut_q <= shut_d;
		end
	end

	// ==========================================
	// output pin
	// a duty beyond the period never matches, so the pin stays high
	assign dutyActive = {dutyShadowHigh_q, dutyLatch_q};
	assign timeNow    = {count_q, fine};
	assign dutyHit    = (dutyActive == timeNow);
	assign dutyZero   = ({dutyWriteByte, dutyLowBits} == pwm_duty_compare_pkg::DUTY_ZERO);

	always_comb begin
		pin_d = pin_q;
		if (periodMatch) begin
			pin_d = !dutyZero;
		end else if (dutyHit) begin
			pin_d = 1'b0;
		end
	end

	// disable parks the pin low, like the timer
	always_ff @(posedge clk) begin
		if (rst || !pwmEnable) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= pin_d;
		end
	end
	// both terms are flops, so the pin carries no decode glitch
	assign pwmOutputPin = pin_q && !shut_q;
endmodule

// ==== tb/pwm_load_model.sv ====
`timescale 1ns/1ps
// ==== load: width of the last high pulse
module pwm_load_model (
	input  wire logic        clk,
	input  wire logic        pin,
	output logic      [15:0] highCnt
);
	logic [15:0] run_q;
	always_ff @(posedge clk) run_q <= pin ? run_q + 16'h1 : 16'h0;
	always_ff @(posedge clk) if (!pin && run_q != 16'h0) highCnt <= run_q;
endmodule

// ==== tb/pwm_duty_compare_monitor.sv ====
`timescale 1ns/1ps
// ==== checks
module pwm_duty_compare_monitor (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       pwmEnable,
	input wire logic [7:0] periodLimitReg,
	input wire logic [7:0] periodTimerCount,
	input wire logic [1:0] dutyLowBits,
	input wire logic [7:0] dutyWriteByte,
	input wire logic       shutdownReq,
	input wire logic       periodMatch,
	input wire logic       pwmOutputPin
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence load; periodMatch && !shutdownReq && dutyWriteByte != 8'h0; endsequence
	a_pin_set: assert property (load |=> pwmOutputPin) else $error("no set");
	a_rise_src: assert property ($rose(pwmOutputPin) |-> $past(periodMatch))
		else $error("odd rise");
	a_shut_low: assert property (shutdownReq |=> !pwmOutputPin) else $error("pin high");
	sequence zeroLoad; periodMatch && {dutyWriteByte, dutyLowBits} == 10'h000; endsequence
	a_match_limit: assert property (periodMatch |-> periodTimerCount == periodLimitReg)
		else $error("match off limit");
	a_match_clear: assert property (periodMatch |=> periodTimerCount == 8'h00)
		else $error("timer not cleared");
	a_zero_low: assert property (zeroLoad |=> !pwmOutputPin) else $error("zero duty high");
	a_off_low: assert property (!pwmEnable |=> !pwmOutputPin) else $error("disabled high");
endmodule
bind pwm_duty_compare pwm_duty_compare_monitor mon_u (.*);

// ==== tb/tb.sv ====
`timescale 1ns/1ps
// ==== bench
module tb;
	logic       clk = 1'b0, rst = 1'b1, en = 1'b0, sd = 1'b0, m, pin;
	logic [7:0] lim = 8'h3, db = 8'h2, cnt;
	logic [1:0] pre = 2'h0, lb = 2'h3;
	int         fails = 0, compares = 0;
	always #2 clk = ~clk;
	pwm_duty_compare dut_u (.clk, .rst, .pwmEnable(en), .periodLimitReg(lim), .dutyWriteByte(db),
		.dutyLowBits(lb), .prescaleSel(pre), .shutdownReq(sd), .periodTimerCount(cnt),
		.periodMatch(m), .pwmOutputPin(pin));
	pwm_load_model load_u (.clk, .pin, .highCnt());
	task check(input logic [15:0] s, e);
		compares++;
		fails += s !== e;
		if (s !== e) $display("wrong value %0t %h %h", $time, s, e);
	endtask
	task final_report;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task periods(input int n);
		for (int t = 0; n > 0 && t < 9999; t++) @(negedge clk) n -= m;
		check(16'(n), 16'h0);
		if (n > 0) final_report();
	endtask
	task ratio(input int i);
		pre = 2'(i);
		periods(3);
		check(16'(cnt), 16'(lim));
		check(load_u.highCnt, (16'hB << (2 * i)) + 16'h1);
		$display("ratio %0d done", i);
	endtask
	task long_duty;
		{pre, lim, db} = {2'h0, 8'h1, 8'h3};
		periods(2);
		repeat (16) @(negedge clk) check(16'(pin), 16'h1);
		sd = 1'b1;
		periods(1);
		@(negedge clk) check(16'(pin), 16'h0);
		$display("long duty done");
	endtask
	task zero_duty;
		{sd, db, lb} = {1'b0, 8'h0, 2'h0};
		periods(2);
		repeat (8) @(negedge clk) check(16'(pin), 16'h0);
		en = 1'b0;
		@(negedge clk) check(16'(cnt), 16'h0);
		check(16'(pin), 16'h0);
		en = 1'b1;
		$display("zero duty done");
	endtask
	initial begin
		repeat (20) @(negedge clk);
		{rst, en} = 2'b01;
		for (int i = 0; i < 3; i++) ratio(i);
		long_duty();
		zero_duty();
		final_report();
	end
endmodule
